// ---- pdc_power_ctrl.sv ----
// Design decisions made here: register access over APB and the register addresses.
`timescale 1ns/1ps
// Function
// - Active divider: 0XX undivided, 1xx /8../64
// - Active divider applies only at sleep
// - Subactive divider: 00 /8, 01 /4, 1X /2
// - Subactive divider applies only at sleep
// - Mode bits plus standby select pick mode
// - Sleep, subsleep, standby, direct and wake paths
// - Transition with sleep kind set resets units
// - Mode clock register resets 0, read-write
// - Reserved standby bit always reads zero
// - I2C standby bit stops I2C unit
// - Serial standby bit stops serial unit
// - ADC standby bit stops converter
module pdc_power_ctrl
  import pdc_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Processor events
  input wire logic sleep_exec,
  input wire logic irq_return,
  input wire logic watch_tick,
  // Clock enables and mode
  output logic sys_clk_en,
  output logic sub_clk_en,
  output logic [4:0] op_mode,
  output logic cpu_halt,
  output logic osc_run,
  // Peripheral control
  output logic i2c_unit_standby,
  output logic serial_unit_standby,
  output logic adc_unit_standby,
  output logic i2c_clk_en,
  output logic serial_clk_en,
  output logic adc_clk_en,
  output logic timer_unit_init,
  output logic serial_unit_init,
  output logic adc_unit_init
);

  // ****************************************
  // APB decode
  // ****************************************
  logic [7:0] power_mode_clock_select;
  logic [2:0] peripheral_standby_control;
  logic standby_select;
  logic [2:0] applied_active_div;
  logic [1:0] applied_sub_div;
  pdc_mode_e mode;
  pdc_mode_e next_mode;

  wire setup = psel && !penable;
  wire access = psel && penable;
  wire hit_mc = paddr == PDC_OFS_MODE_CLK;
  wire hit_sb = paddr == PDC_OFS_STANDBY;
  wire hit_pc = paddr == PDC_OFS_PWR_CFG;
  wire hit_st = paddr == PDC_OFS_STATUS;
  wire addr_ok = hit_mc || hit_sb || hit_pc || hit_st;
  wire wr_ok = access && pwrite && addr_ok;
  wire wr_mc = wr_ok && hit_mc;
  wire wr_sb = wr_ok && hit_sb;
  wire wr_pc = wr_ok && hit_pc;

  assign pready = access;
  assign pslverr = access && !addr_ok;

  // ****************************************
  // Read data
  // ****************************************
  wire [7:0] rd_sb = {1'b0, peripheral_standby_control, 4'h0};
  wire [31:0] rd_st = {18'h0, applied_sub_div, 1'b0, applied_active_div, 3'h0, mode};
  wire [31:0] rd_mux = hit_mc ? {24'h0, power_mode_clock_select} :
                       hit_sb ? {24'h0, rd_sb} :
                       hit_pc ? {31'h0, standby_select} :
                       hit_st ? rd_st : 32'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (setup) begin
      prdata <= pwrite ? 32'h0 : rd_mux;
    end
  end

  // ****************************************
  // Control registers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_mode_clock_select <= PDC_RST_MODE_CLK;
      peripheral_standby_control <= PDC_RST_STANDBY;
      standby_select <= PDC_RST_STBY_SEL;
    end else begin
      if (wr_mc) begin
        power_mode_clock_select <= pwdata[7:0];
      end
      if (wr_sb) begin
        peripheral_standby_control <= pwdata[PDC_BIT_I2C:PDC_BIT_ADC];
      end
      if (wr_pc) begin
        standby_select <= pwdata[PDC_BIT_STBY_SEL];
      end
    end
  end

  // ****************************************
  // Mode selection
  // ****************************************
  wire sleep_kind = power_mode_clock_select[PDC_BIT_SLEEP_KIND];
  wire low_speed = power_mode_clock_select[PDC_BIT_LOW_SPEED];
  wire direct_xfer = power_mode_clock_select[PDC_BIT_DIRECT];
  wire running = (mode == MODE_ACTIVE) || (mode == MODE_SUBACTIVE);
  wire halted = !running;
  wire take_sleep = sleep_exec && running;
  wire take_wake = irq_return && halted;

  pdc_mode_e sleep_target;
  pdc_mode_e wake_target;
  assign sleep_target = direct_xfer ? (low_speed ? MODE_SUBACTIVE : MODE_ACTIVE) :
                        standby_select ? MODE_STANDBY :
                        sleep_kind ? MODE_SUBSLEEP : MODE_SLEEP;
  assign wake_target = (mode == MODE_STANDBY) ? MODE_ACTIVE :
                       low_speed ? MODE_SUBACTIVE : MODE_ACTIVE;

  always_comb begin
    next_mode = mode;
    case (mode)
      MODE_ACTIVE, MODE_SUBACTIVE: begin
        if (take_sleep) begin
          next_mode = sleep_target;
        end
      end
      MODE_SLEEP, MODE_SUBSLEEP, MODE_STANDBY: begin
        if (take_wake) begin
          next_mode = wake_target;
        end
      end
      default: begin
        next_mode = MODE_ACTIVE;
      end
    endcase
  end

  wire mode_change = next_mode != mode;
  wire unit_init = mode_change && sleep_kind;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode <= MODE_ACTIVE;
      timer_unit_init <= 1'b0;
      serial_unit_init <= 1'b0;
      adc_unit_init <= 1'b0;
    end else begin
      mode <= next_mode;
      timer_unit_init <= unit_init;
      serial_unit_init <= unit_init;
      adc_unit_init <= unit_init;
    end
  end

  // ****************************************
  // Divider latching at sleep
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      applied_active_div <= 3'h0;
      applied_sub_div <= 2'h0;
    end else if (take_sleep) begin
      applied_active_div <= power_mode_clock_select[PDC_ACT_DIV_HI:PDC_ACT_DIV_LO];
      applied_sub_div <= power_mode_clock_select[PDC_SUB_DIV_HI:PDC_SUB_DIV_LO];
    end
  end

  wire [2:0] act_shift = applied_active_div[2] ?
                         (PDC_SHIFT_ACT_BASE + {1'b0, applied_active_div[1:0]}) :
                         PDC_SHIFT_NONE;
  wire [2:0] sub_shift = applied_sub_div[1] ? PDC_SHIFT_SUB_2 :
                         applied_sub_div[0] ? PDC_SHIFT_SUB_4 : PDC_SHIFT_SUB_8;

  // ****************************************
  // Clock dividers
  // ****************************************
  wire osc_on = (mode == MODE_ACTIVE) || (mode == MODE_SLEEP);
  wire sub_on = (mode == MODE_SUBACTIVE) || (mode == MODE_SUBSLEEP);

  pdc_clk_div u_act_div (
    .pclk(pclk),
    .presetn(presetn),
    .tick(osc_on),
    .shift(act_shift),
    .en(sys_clk_en)
  );

  pdc_clk_div u_sub_div (
    .pclk(pclk),
    .presetn(presetn),
    .tick(watch_tick && sub_on),
    .shift(sub_shift),
    .en(sub_clk_en)
  );

  // ****************************************
  // Outputs
  // ****************************************
  assign op_mode = mode;
  assign cpu_halt = halted;
  assign osc_run = osc_on;
  assign i2c_unit_standby = peripheral_standby_control[2];
  assign serial_unit_standby = peripheral_standby_control[1];
  assign adc_unit_standby = peripheral_standby_control[0];
  assign i2c_clk_en = !peripheral_standby_control[2];
  assign serial_clk_en = !peripheral_standby_control[1];
  assign adc_clk_en = !peripheral_standby_control[0];

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_active_div_hold: assert property ($changed(applied_active_div) |-> $past(take_sleep))
    else $error("active divider changed without sleep");
  a_sub_div_hold: assert property ($changed(applied_sub_div) |-> $past(take_sleep))
    else $error("subactive divider changed without sleep");
  a_div_latch: assert property (take_sleep |=> applied_active_div == $past(power_mode_clock_select[4:2]))
    else $error("active divider not taken at sleep");
  a_sub_latch: assert property (take_sleep |=> applied_sub_div == $past(power_mode_clock_select[1:0]))
    else $error("subactive divider not taken at sleep");
  a_full_rate: assert property ((!applied_active_div[2] && !$past(applied_active_div[2]) && osc_on
      && $past(osc_on) && $past(presetn)) |-> sys_clk_en)
    else $error("undivided clock enable missing");
  a_div8_gap: assert property ((applied_active_div == 3'h4 && $past(applied_active_div) == 3'h4
      && osc_on && sys_clk_en) |=>
      (!sys_clk_en [*7]) or (##[0:6] $changed(applied_active_div) or !osc_on))
    else $error("divide by eight spacing wrong");
  a_sys_stop: assert property ((!osc_on && !$past(osc_on)) |-> !sys_clk_en)
    else $error("system enable while oscillator off");
  a_sub_stop: assert property ((!sub_on && !$past(sub_on)) |-> !sub_clk_en)
    else $error("subclock enable outside subactive");
  a_sub_div2_gap: assert property ((applied_sub_div[1] && $past(applied_sub_div[1])
      && sub_clk_en) |=> !sub_clk_en)
    else $error("divide by two spacing wrong");
  a_sleep_entry: assert property ((take_sleep && !direct_xfer && !standby_select) |=>
      mode == ($past(sleep_kind) ? MODE_SUBSLEEP : MODE_SLEEP))
    else $error("wrong sleep target");
  a_standby_entry: assert property ((take_sleep && !direct_xfer && standby_select) |=> mode == MODE_STANDBY)
    else $error("standby not entered");
  a_direct_xfer: assert property ((take_sleep && direct_xfer) |=>
      mode == ($past(low_speed) ? MODE_SUBACTIVE : MODE_ACTIVE))
    else $error("direct transfer target wrong");
  a_standby_wake: assert property ((mode == MODE_STANDBY && irq_return) |=> mode == MODE_ACTIVE)
    else $error("standby wake not to active");
  a_wake_target: assert property ((take_wake && mode != MODE_STANDBY) |=>
      mode == ($past(low_speed) ? MODE_SUBACTIVE : MODE_ACTIVE))
    else $error("wake target wrong");
  a_sleep_ignored: assert property ((sleep_exec && halted && !irq_return) |=> $stable(mode))
    else $error("sleep taken while halted");
  a_halt_decode: assert property (cpu_halt == (op_mode != MODE_ACTIVE && op_mode != MODE_SUBACTIVE))
    else $error("halt flag disagrees with mode");
  a_mode_onehot: assert property ($onehot(op_mode))
    else $error("mode not one-hot");
  a_no_wait: assert property (access |-> pready && (pslverr == !addr_ok))
    else $error("bus answer wrong");
  a_unit_init: assert property ((mode_change && sleep_kind) |=> timer_unit_init && serial_unit_init
      && adc_unit_init)
    else $error("units not reset on transition");
  a_no_init: assert property (!mode_change |=> !adc_unit_init)
    else $error("spurious unit reset");
  a_reg_write: assert property (wr_mc |=> power_mode_clock_select == $past(pwdata[7:0]))
    else $error("mode clock register write lost");
  a_rsv_zero: assert property ((access && !pwrite && hit_sb) |-> prdata[PDC_BIT_RSV] == 1'b0)
    else $error("reserved bit read nonzero");
  a_i2c_stby: assert property ((wr_sb && pwdata[PDC_BIT_I2C]) |=> i2c_unit_standby && !i2c_clk_en)
    else $error("i2c standby not applied");
  a_serial_stby: assert property ((wr_sb && pwdata[PDC_BIT_SERIAL]) |=> serial_unit_standby)
    else $error("serial standby not applied");
  a_adc_stby: assert property ((wr_sb && pwdata[PDC_BIT_ADC]) |=> adc_unit_standby)
    else $error("adc standby not applied");
  a_stby_release: assert property ((wr_sb && !pwdata[PDC_BIT_ADC]) |=> adc_clk_en && serial_clk_en
      == !$past(pwdata[PDC_BIT_SERIAL]))
    else $error("standby release failed");

  // ****************************************
  // Coverage
  // ****************************************
  c_sleep_wake: cover property (mode == MODE_SLEEP ##1 mode == MODE_ACTIVE);
  c_subactive: cover property (take_sleep && direct_xfer && low_speed);
  c_standby_wake: cover property (mode == MODE_STANDBY && irq_return);
  c_unit_init: cover property (adc_unit_init);
  c_sub_div2: cover property (sub_clk_en && applied_sub_div[1]);

endmodule

// ---- pdc_pkg.sv ----
package pdc_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] PDC_OFS_MODE_CLK = 8'h00;
  localparam logic [7:0] PDC_OFS_STANDBY = 8'h04;
  localparam logic [7:0] PDC_OFS_PWR_CFG = 8'h08;
  localparam logic [7:0] PDC_OFS_STATUS = 8'h0c;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] PDC_RST_MODE_CLK = 8'h00;
  localparam logic [2:0] PDC_RST_STANDBY = 3'h0;
  localparam logic PDC_RST_STBY_SEL = 1'b0;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int PDC_BIT_SLEEP_KIND = 7;
  localparam int PDC_BIT_LOW_SPEED = 6;
  localparam int PDC_BIT_DIRECT = 5;
  localparam int PDC_ACT_DIV_HI = 4;
  localparam int PDC_ACT_DIV_LO = 2;
  localparam int PDC_SUB_DIV_HI = 1;
  localparam int PDC_SUB_DIV_LO = 0;
  localparam int PDC_BIT_RSV = 7;
  localparam int PDC_BIT_I2C = 6;
  localparam int PDC_BIT_SERIAL = 5;
  localparam int PDC_BIT_ADC = 4;
  localparam int PDC_BIT_STBY_SEL = 0;
  localparam int PDC_STAT_MODE_LO = 0;
  localparam int PDC_STAT_ACT_LO = 8;
  localparam int PDC_STAT_SUB_LO = 12;

  // ****************************************
  // Divider shifts (log2 of ratio)
  // ****************************************
  localparam logic [2:0] PDC_SHIFT_ACT_BASE = 3'h3;
  localparam logic [2:0] PDC_SHIFT_NONE = 3'h0;
  localparam logic [2:0] PDC_SHIFT_SUB_8 = 3'h3;
  localparam logic [2:0] PDC_SHIFT_SUB_4 = 3'h2;
  localparam logic [2:0] PDC_SHIFT_SUB_2 = 3'h1;
  localparam int PDC_DIV_CNT_W = 6;

  // ****************************************
  // Operating modes
  // ****************************************
  typedef enum logic [4:0] {
    MODE_ACTIVE = 5'h01,
    MODE_SLEEP = 5'h02,
    MODE_SUBACTIVE = 5'h04,
    MODE_SUBSLEEP = 5'h08,
    MODE_STANDBY = 5'h10
  } pdc_mode_e;

endpackage

// ---- pdc_clk_div.sv ----
`timescale 1ns/1ps
module pdc_clk_div
  import pdc_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Source tick and ratio
  input wire logic tick,
  input wire logic [2:0] shift,
  // Divided enable
  output logic en
);

  // ****************************************
  // Power-of-two divider
  // ****************************************
  logic [PDC_DIV_CNT_W-1:0] cnt;
  wire [PDC_DIV_CNT_W-1:0] mask = ~({PDC_DIV_CNT_W{1'b1}} << shift);
  wire hit = tick && ((cnt & mask) == mask);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= '0;
      en <= 1'b0;
    end else begin
      if (tick) begin
        cnt <= cnt + 1'b1;
      end
      en <= hit;
    end
  end

endmodule

// ---- pdc_power_ctrl_tb_top.sv ----
`timescale 1ns/1ps
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin fails++; $display("BAD %s exp %h got %h", n, e, s); end end
module pdc_power_ctrl_tb_top
  import pdc_pkg::*;
;
  // ****************************************
  // Stimulus and model state
  // ****************************************
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, sleep_exec = 1'b0, irq_return = 1'b0, watch_tick = 1'b0;
  logic sys_clk_en, sub_clk_en, cpu_halt, osc_run, i2c_unit_standby, serial_unit_standby, adc_unit_standby;
  logic i2c_clk_en, serial_clk_en, adc_clk_en, timer_unit_init, serial_unit_init, adc_unit_init;
  logic [4:0] op_mode;
  logic [1:0] wc = 2'h0;
  int fails = 0, total_checks = 0, p, r;
  int m_mode = 1, m_act = 0, m_sub = 0, m_reg0 = 0, m_stby = 0, m_ssel = 0, m_init = 0, seen_init = 0;

  pdc_power_ctrl i_pdc_power_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sleep_exec(sleep_exec), .irq_return(irq_return), .watch_tick(watch_tick), .sys_clk_en(sys_clk_en),
    .sub_clk_en(sub_clk_en), .op_mode(op_mode), .cpu_halt(cpu_halt), .osc_run(osc_run),
    .i2c_unit_standby(i2c_unit_standby), .serial_unit_standby(serial_unit_standby),
    .adc_unit_standby(adc_unit_standby), .i2c_clk_en(i2c_clk_en), .serial_clk_en(serial_clk_en),
    .adc_clk_en(adc_clk_en), .timer_unit_init(timer_unit_init), .serial_unit_init(serial_unit_init),
    .adc_unit_init(adc_unit_init));

  initial begin
    forever #2.5 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    wc <= wc + 2'h1;
    watch_tick <= (wc == 2'h3);
    if (timer_unit_init === 1'b1 && serial_unit_init === 1'b1 && adc_unit_init === 1'b1) seen_init++;
  end

  // ****************************************
  // Tasks
  // ****************************************
  task close_out;
    if (fails == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      fails++;
      close_out();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    if (a == 8'h00) m_reg0 = d[7:0];
    if (a == 8'h04) m_stby = d & 32'h70;
    if (a == 8'h08) m_ssel = d[0];
    `CHK("pslverr_w", a > 8'h0c, er)
  endtask

  task rdchk(input logic [7:0] a, input int e);
    apb(1'b0, a, 32'h0);
    `CHK("prdata", e, rd)
    `CHK("pslverr_r", a > 8'h0c, er)
  endtask

  task stby_chk;
    @(negedge pclk);
    `CHK("i2c_stby", m_stby[6], i2c_unit_standby)
    `CHK("ser_stby", m_stby[5], serial_unit_standby)
    `CHK("adc_stby", m_stby[4], adc_unit_standby)
    `CHK("clk_ens", ~m_stby[6:4], {i2c_clk_en, serial_clk_en, adc_clk_en})
  endtask

  task ev(input logic s, input logic i);
    int nm;
    logic run;
    run = (m_mode == 1 || m_mode == 4);
    nm = m_mode;
    if (s && run) begin
      m_act = (m_reg0 >> 2) & 7;
      m_sub = m_reg0 & 3;
      if (m_reg0[5]) nm = m_reg0[6] ? 4 : 1;
      else if (m_ssel) nm = 16;
      else nm = m_reg0[7] ? 8 : 2;
    end
    if (i && !run) nm = (m_mode == 16 || !m_reg0[6]) ? 1 : 4;
    if (nm != m_mode && m_reg0[7]) m_init++;
    m_mode = nm;
    @(posedge pclk);
    sleep_exec <= s; irq_return <= i;
    @(posedge pclk);
    sleep_exec <= 1'b0; irq_return <= 1'b0;
    @(negedge pclk);
    `CHK("op_mode", m_mode[4:0], op_mode)
    `CHK("cpu_halt", m_mode == 2 || m_mode == 8 || m_mode == 16, cpu_halt)
    `CHK("osc_run", m_mode == 1 || m_mode == 2, osc_run)
  endtask

  task period(input logic which, output int q);
    int n;
    logic v;
    q = 0; n = 0;
    do begin
      @(posedge pclk);
      v = which ? sub_clk_en : sys_clk_en;
      n++;
    end while (v !== 1'b1 && n < 100);
    if (v === 1'b1) begin
      n = 0;
      do begin
        @(posedge pclk);
        v = which ? sub_clk_en : sys_clk_en;
        n++;
      end while (v !== 1'b1 && n < 100);
      q = n;
    end
  endtask

  function int sys_exp();
    if (m_mode != 1 && m_mode != 2) return 0;
    return (m_act < 4) ? 1 : (8 << (m_act - 4));
  endfunction

  function int sub_exp();
    if (m_mode != 4 && m_mode != 8) return 0;
    return (m_sub >= 2) ? 8 : (m_sub == 1 ? 16 : 32);
  endfunction

  function int stat();
    return m_mode | (m_act << 8) | (m_sub << 12);
  endfunction

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    void'($urandom(32'hc970));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(8'h00, 0);
    rdchk(8'h04, 0);
    rdchk(8'h08, 0);
    rdchk(8'h0c, stat());
    stby_chk();
    for (int k = 0; k < 6; k++) begin
      wr(8'h04, (k == 0) ? 32'hffffffff : $urandom);
      rdchk(8'h04, m_stby);
      stby_chk();
    end
    wr(8'h04, 32'h0);
    stby_chk();
    wr(8'h10, 32'hff);
    rdchk(8'h10, 0);
    wr(8'h0c, 32'hffff);
    for (int k = 0; k < 4; k++) begin
      wr(8'h00, $urandom & 32'hff);
      rdchk(8'h00, m_reg0);
    end
    rdchk(8'h0c, stat());
    for (int c = 0; c < 8; c++) begin
      wr(8'h00, 32'h20 | (c << 2));
      period(1'b0, p);
      `CHK("sys_before", sys_exp(), p)
      ev(1'b1, 1'b0);
      rdchk(8'h0c, stat());
      period(1'b0, p);
      `CHK("sys_after", sys_exp(), p)
    end
    for (int c = 0; c < 4; c++) begin
      wr(8'h00, 32'h60 | c);
      rdchk(8'h0c, stat());
      ev(1'b1, 1'b0);
      period(1'b1, p);
      `CHK("sub_period", sub_exp(), p)
      period(1'b0, p);
      `CHK("sys_off", sys_exp(), p)
    end
    for (int k = 0; k < 40; k++) begin
      r = $urandom;
      wr(8'h08, r[8]);
      wr(8'h00, r[7:0]);
      if (r[9] & r[10]) ev(m_mode == 2 || m_mode == 8 || m_mode == 16, m_mode == 1 || m_mode == 4);
      else ev(m_mode == 1 || m_mode == 4, !(m_mode == 1 || m_mode == 4));
      rdchk(8'h0c, stat());
    end
    repeat (4) @(posedge pclk);
    `CHK("init_pulses", m_init, seen_init)
    close_out();
  end

  initial begin
    #400000;
    fails++;
    close_out();
  end
endmodule
